// [inc/smb_pkg.sv]
package smb_pkg;
  localparam int REF_HZ      = 40_000_000;
  localparam int CYC_PER_MS  = REF_HZ / 1000;
  localparam int HD_STA_NS   = 4000;
  localparam int SCL_TMO_MS  = 25;
  localparam int EE_PROG_MS  = 5;
  localparam int QTR_CYC     = (HD_STA_NS * (REF_HZ / 1_000_000) + 999)
                               / 1000;
  localparam int SCL_TMO_CYC = SCL_TMO_MS * CYC_PER_MS;
  localparam int EE_PROG_CYC = EE_PROG_MS * CYC_PER_MS;
  localparam int EE_DEPTH    = 256;

  localparam logic [7:0] CTL_ADDR_BASE = 8'hb0;
  localparam logic [7:0] EE_ADDR_BASE  = 8'ha0;
  localparam logic [7:0] ADDR_SEL_STEP = 8'h02;
  localparam logic [7:0] BLK_MAX       = 8'hff;
  localparam logic [3:0] ACK_BIT       = 4'h8;
  localparam logic [3:0] LAST_BIT      = 4'h7;
  localparam logic [2:0] LOC_STEP      = 3'h2;
  localparam logic [2:0] SY_RESET      = 3'h7;

  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_SEL = 2;

  typedef enum logic [1:0] {D_ADDR, D_WRITE, D_READ, D_IGNORE} smb_dev_st_t;
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_WAIT} smb_host_st_t;
  typedef enum logic [1:0] {OP_START, OP_SEND, OP_RECV, OP_STOP} smb_op_t;

  function automatic logic [7:0] smb_tgt_addr(input logic [7:0] base,
                                              input logic       sel);
    return base + (sel ? ADDR_SEL_STEP : 8'h00);
  endfunction
endpackage

// [inc/smb_link_if.sv]
interface smb_link_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic scl;
  logic sda;

  // wired-and of the open-drain drivers with pull-up
  assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

  modport dev (
    input  scl,
    input  sda,
    output dev_scl_o,
    output dev_scl_oe,
    output dev_sda_o,
    output dev_sda_oe
  );
  modport host (
    input  scl,
    input  sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface

// [verilog/smb_dev.sv]
module smb_dev #(
  parameter int TMO_LIMIT = smb_pkg::SCL_TMO_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       address_select_pin,
  smb_link_if.dev         bus,
  output logic            ctl_wr_valid,
  output logic [7:0]      ctl_wr_data,
  output logic            ctl_wr_first,
  output logic            ctl_rd_req,
  input  wire logic [7:0] ctl_rd_data
);
  import smb_pkg::*;
  localparam int TW = $clog2(TMO_LIMIT + 1);
  logic [2:0]    sy1, sy2, sy3, filt, filt_d;
  logic [2:0]    next_sy1, next_sy2, next_sy3, next_filt, next_filt_d;
  logic [TW-1:0] lowcnt, next_lowcnt;
  logic          frame_rst, start_d, ws1, ws2, ws3, rs1, rs2, rs3;
  logic          next_frame_rst, next_start_d, next_ctl_wr_valid;
  logic          next_ctl_wr_first, next_ctl_rd_req;
  logic          start_det, stop_det, tmo;
  logic [7:0]    rd_hold, next_rd_hold, next_ctl_wr_data;
  smb_dev_st_t   st, next_st;
  logic [3:0]    bitcnt, next_bitcnt;
  logic [7:0]    shreg, next_shreg, wcnt, next_wcnt;
  logic [7:0]    wr_byte, next_wr_byte, loc, next_loc;
  logic [7:0]    byte_in, ctl_a, ee_a, tx;
  logic [7:0]    mem [EE_DEPTH];
  logic          ack, next_ack, is_ee, next_is_ee;
  logic          wr_tgl, next_wr_tgl, rd_tgl, next_rd_tgl;
  logic          wr_first, next_wr_first, sel_s1, sel_s2;
  logic          mem_we, sda_oe, next_sda_oe, bus_rst_n;
  always_comb begin
    next_sy1 = {address_select_pin, bus.sda, bus.scl};
    next_sy2 = sy1;
    next_sy3 = sy2;
    for (int i = 0; i < 3; i++) begin
      next_filt[i] = (sy2[i] == sy3[i]) ? sy3[i] : filt[i];
    end
    next_filt_d = filt;
    start_det = filt[SY_SCL] & filt_d[SY_SCL]
              & filt_d[SY_SDA] & ~filt[SY_SDA];
    stop_det  = filt[SY_SCL] & filt_d[SY_SCL]
              & ~filt_d[SY_SDA] & filt[SY_SDA];
    tmo = (lowcnt == TW'(TMO_LIMIT));
    next_lowcnt = filt[SY_SCL] ? '0 : (tmo ? lowcnt : lowcnt + 1'b1);
    next_start_d = start_det;
    // pulse reset on start, hold it after stop or timeout
    next_frame_rst = start_det | stop_det | tmo
                   | (frame_rst & ~start_d);
    next_ctl_wr_valid = ws2 ^ ws3;
    next_ctl_wr_data  = (ws2 ^ ws3) ? wr_byte : ctl_wr_data;
    next_ctl_wr_first = (ws2 ^ ws3) ? wr_first : ctl_wr_first;
    next_ctl_rd_req   = rs2 ^ rs3;
    next_rd_hold      = ctl_rd_req ? ctl_rd_data : rd_hold;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1          <= SY_RESET;
      sy2          <= SY_RESET;
      sy3          <= SY_RESET;
      filt         <= SY_RESET;
      filt_d       <= SY_RESET;
      lowcnt       <= '0;
      frame_rst    <= 1'b1;
      start_d      <= 1'b0;
      ws1          <= 1'b0;
      ws2          <= 1'b0;
      ws3          <= 1'b0;
      rs1          <= 1'b0;
      rs2          <= 1'b0;
      rs3          <= 1'b0;
      ctl_wr_valid <= 1'b0;
      ctl_wr_data  <= 8'h00;
      ctl_wr_first <= 1'b0;
      ctl_rd_req   <= 1'b0;
      rd_hold      <= 8'h00;
    end else begin
      sy1          <= next_sy1;
      sy2          <= next_sy2;
      sy3          <= next_sy3;
      filt         <= next_filt;
      filt_d       <= next_filt_d;
      lowcnt       <= next_lowcnt;
      frame_rst    <= next_frame_rst;
      start_d      <= next_start_d;
      ws1          <= wr_tgl;
      ws2          <= ws1;
      ws3          <= ws2;
      rs1          <= rd_tgl;
      rs2          <= rs1;
      rs3          <= rs2;
      ctl_wr_valid <= next_ctl_wr_valid;
      ctl_wr_data  <= next_ctl_wr_data;
      ctl_wr_first <= next_ctl_wr_first;
      ctl_rd_req   <= next_ctl_rd_req;
      rd_hold      <= next_rd_hold;
    end
  end
  assign bus_rst_n = ~frame_rst;
  always_comb begin
    byte_in       = {shreg[6:0], bus.sda};
    ctl_a         = smb_tgt_addr(CTL_ADDR_BASE, sel_s2);
    ee_a          = smb_tgt_addr(EE_ADDR_BASE, sel_s2);
    next_st       = st;
    next_bitcnt   = bitcnt;
    next_shreg    = shreg;
    next_ack      = ack;
    next_is_ee    = is_ee;
    next_wcnt     = wcnt;
    next_wr_tgl   = wr_tgl;
    next_rd_tgl   = rd_tgl;
    next_wr_byte  = wr_byte;
    next_wr_first = wr_first;
    next_loc      = loc;
    mem_we        = 1'b0;
    if (bitcnt != ACK_BIT) begin
      next_shreg  = byte_in;
      next_bitcnt = bitcnt + 4'd1;
      if (bitcnt == LAST_BIT) begin
        case (st)
          D_ADDR: begin
            if (byte_in[7:1] == ctl_a[7:1]) begin
              next_ack   = 1'b1;
              next_is_ee = 1'b0;
              if (byte_in[0]) begin
                next_rd_tgl = ~rd_tgl;
              end
            end else if (byte_in[7:1] == ee_a[7:1]) begin
              next_ack   = 1'b1;
              next_is_ee = 1'b1;
            end else begin
              next_ack = 1'b0;
            end
          end
          D_WRITE: begin
            next_ack  = (wcnt != BLK_MAX);
            next_wcnt = wcnt + 8'd1;
            if (is_ee) begin
              if (wcnt == 8'd0) begin
                next_loc = byte_in;
              end else begin
                mem_we   = 1'b1;
                next_loc = loc + 8'd1;
              end
            end else begin
              next_wr_byte  = byte_in;
              next_wr_first = (wcnt == 8'd0);
              next_wr_tgl   = ~wr_tgl;
            end
          end
          default: begin
            next_ack = 1'b0;
          end
        endcase
      end
    end else begin
      next_bitcnt = 4'd0;
      case (st)
        D_ADDR: begin
          if (!ack) begin
            next_st = D_IGNORE;
          end else if (shreg[0]) begin
            next_st = D_READ;
          end else begin
            next_st = D_WRITE;
          end
        end
        D_WRITE: begin
          if (!ack) begin
            next_st = D_IGNORE;
          end
        end
        D_READ: begin
          if (is_ee) begin
            next_loc = loc + 8'd1;
          end
          if (bus.sda) begin
            next_st = D_IGNORE;
          end else if (!is_ee) begin
            next_rd_tgl = ~rd_tgl;
          end
        end
        default: begin
          next_st = D_IGNORE;
        end
      endcase
    end
  end
  always_ff @(posedge bus.scl or negedge bus_rst_n) begin
    if (!bus_rst_n) begin
      st     <= D_ADDR;
      bitcnt <= 4'd0;
      shreg  <= 8'h00;
      ack    <= 1'b0;
      is_ee  <= 1'b0;
      wcnt   <= 8'h00;
    end else begin
      st     <= next_st;
      bitcnt <= next_bitcnt;
      shreg  <= next_shreg;
      ack    <= next_ack;
      is_ee  <= next_is_ee;
      wcnt   <= next_wcnt;
    end
  end
  always_ff @(posedge bus.scl or negedge rst_n) begin
    if (!rst_n) begin
      wr_tgl   <= 1'b0;
      rd_tgl   <= 1'b0;
      wr_byte  <= 8'h00;
      wr_first <= 1'b0;
      loc      <= 8'h00;
      sel_s1   <= 1'b1;
      sel_s2   <= 1'b1;
    end else begin
      wr_tgl   <= next_wr_tgl;
      rd_tgl   <= next_rd_tgl;
      wr_byte  <= next_wr_byte;
      wr_first <= next_wr_first;
      loc      <= next_loc;
      sel_s1   <= filt[SY_SEL];
      sel_s2   <= sel_s1;
    end
  end
  always_ff @(posedge bus.scl) begin
    if (mem_we) begin
      mem[loc] <= byte_in;
    end
  end
  always_comb begin
    tx = is_ee ? mem[loc] : rd_hold;
    if (bitcnt == ACK_BIT) begin
      next_sda_oe = ack & (st != D_READ);
    end else if (st == D_READ) begin
      next_sda_oe = ~tx[3'(LAST_BIT[2:0] - bitcnt[2:0])];
    end else begin
      next_sda_oe = 1'b0;
    end
  end
  always_ff @(negedge bus.scl or negedge bus_rst_n) begin
    if (!bus_rst_n) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= next_sda_oe;
    end
  end
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = sda_oe;
  assign bus.dev_scl_o  = 1'b0;
  assign bus.dev_scl_oe = 1'b0;
endmodule

// [verilog/smb_host.sv]
module smb_host #(
  parameter int PROG_WAIT = smb_pkg::EE_PROG_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  smb_link_if.host        bus,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_dev,
  input  wire logic [7:0] cmd_loc,
  input  wire logic [7:0] cmd_data,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            rsp_nack
);
  import smb_pkg::*;

  localparam int QW = $clog2(QTR_CYC);
  localparam int WW = $clog2(PROG_WAIT + 1);

  function automatic smb_op_t op_of(input logic [2:0] s, input logic r);
    case (s)
      3'd0:    op_of = OP_START;
      3'd3:    op_of = r ? OP_START : OP_SEND;
      3'd4:    op_of = r ? OP_SEND : OP_STOP;
      3'd5:    op_of = OP_RECV;
      3'd6:    op_of = OP_STOP;
      default: op_of = OP_SEND;
    endcase
  endfunction

  function automatic logic [7:0] byte_of(input logic [2:0] s,
                                         input logic [7:0] d,
                                         input logic [7:0] l,
                                         input logic [7:0] w);
    case (s)
      3'd1:    byte_of = {d[7:1], 1'b0};
      LOC_STEP: byte_of = l;
      3'd3:    byte_of = w;
      default: byte_of = {d[7:1], 1'b1};
    endcase
  endfunction

  smb_host_st_t  st;
  smb_host_st_t  next_st;
  logic [QW-1:0] div;
  logic [QW-1:0] next_div;
  logic [WW-1:0] waitcnt;
  logic [WW-1:0] next_waitcnt;
  logic [1:0]    q;
  logic [1:0]    next_q;
  logic [2:0]    step;
  logic [2:0]    next_step;
  logic [3:0]    bitcnt;
  logic [3:0]    next_bitcnt;
  logic [7:0]    sh;
  logic [7:0]    next_sh;
  logic [7:0]    rx;
  logic [7:0]    next_rx;
  logic          rd;
  logic          next_rd;
  logic [7:0]    dev;
  logic [7:0]    next_dev;
  logic [7:0]    loc;
  logic [7:0]    next_loc;
  logic [7:0]    dat;
  logic [7:0]    next_dat;
  logic          nack;
  logic          next_nack;
  logic          next_rsp_valid;
  logic [7:0]    next_rsp_data;
  logic          next_rsp_nack;
  logic [1:0]    sy1;
  logic [1:0]    sy2;
  logic [1:0]    sy3;
  logic [1:0]    filt;
  logic [1:0]    next_filt;
  smb_op_t       op;
  logic          tick;
  logic          stall;
  logic          scl_low;
  logic          sda_low;

  always_comb begin
    op    = op_of(step, rd);
    stall = (st == H_RUN) & (q == 2'd1) & ~filt[SY_SCL];
    tick  = (st == H_RUN) & (div == QW'(QTR_CYC - 1)) & ~stall;
    for (int i = 0; i < 2; i++) begin
      next_filt[i] = (sy2[i] == sy3[i]) ? sy3[i] : filt[i];
    end
    scl_low = (st == H_RUN)
            & ((q == 2'd0) | ((q == 2'd3) & (op != OP_STOP)));
    case (op)
      OP_START: sda_low = (q >= 2'd2);
      OP_STOP:  sda_low = (q <= 2'd1);
      OP_SEND:  sda_low = (bitcnt != ACK_BIT) & ~sh[7];
      default:  sda_low = 1'b0;
    endcase
    if (st != H_RUN) begin
      sda_low = 1'b0;
    end
    next_st        = st;
    next_div       = div;
    next_waitcnt   = waitcnt;
    next_q         = q;
    next_step      = step;
    next_bitcnt    = bitcnt;
    next_sh        = sh;
    next_rx        = rx;
    next_rd        = rd;
    next_dev       = dev;
    next_loc       = loc;
    next_dat       = dat;
    next_nack      = nack;
    next_rsp_valid = 1'b0;
    next_rsp_data  = rsp_data;
    next_rsp_nack  = rsp_nack;
    case (st)
      H_IDLE: begin
        if (cmd_valid) begin
          next_st     = H_RUN;
          next_div    = '0;
          next_q      = 2'd0;
          next_step   = 3'd0;
          next_bitcnt = 4'd0;
          next_nack   = 1'b0;
          next_rx     = 8'h00;
          next_rd     = cmd_read;
          next_dev    = cmd_dev;
          next_loc    = cmd_loc;
          next_dat    = cmd_data;
        end
      end
      H_RUN: begin
        if (tick) begin
          next_div = '0;
          next_q   = q + 2'd1;
          if (q == 2'd2) begin
            if (op == OP_SEND && bitcnt == ACK_BIT) begin
              next_nack = nack | filt[SY_SDA];
            end
            if (op == OP_RECV && bitcnt != ACK_BIT) begin
              next_rx = {rx[6:0], filt[SY_SDA]};
            end
          end
          if (q == 2'd3) begin
            if ((op == OP_SEND || op == OP_RECV) && bitcnt != ACK_BIT) begin
              next_bitcnt = bitcnt + 4'd1;
              next_sh     = {sh[6:0], 1'b0};
            end else if (op == OP_STOP) begin
              next_st        = H_WAIT;
              next_waitcnt   = '0;
              next_rsp_valid = 1'b1;
              next_rsp_data  = rx;
              next_rsp_nack  = nack;
            end else begin
              next_bitcnt = 4'd0;
              if (op == OP_SEND && nack) begin
                next_step = rd ? 3'd6 : 3'd4;
              end else begin
                next_step = step + 3'd1;
              end
              next_sh = byte_of(next_step, dev, loc, dat);
            end
          end
        end else if (div != QW'(QTR_CYC - 1)) begin
          next_div = div + 1'b1;
        end
      end
      H_WAIT: begin
        if (waitcnt == WW'(PROG_WAIT - 1)) begin
          next_st = H_IDLE;
        end else begin
          next_waitcnt = waitcnt + 1'b1;
        end
      end
      default: begin
        next_st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st        <= H_IDLE;
      div       <= '0;
      waitcnt   <= '0;
      q         <= 2'd0;
      step      <= 3'd0;
      bitcnt    <= 4'd0;
      sh        <= 8'h00;
      rx        <= 8'h00;
      rd        <= 1'b0;
      dev       <= 8'h00;
      loc       <= 8'h00;
      dat       <= 8'h00;
      nack      <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_nack  <= 1'b0;
      sy1       <= 2'h3;
      sy2       <= 2'h3;
      sy3       <= 2'h3;
      filt      <= 2'h3;
    end else begin
      st        <= next_st;
      div       <= next_div;
      waitcnt   <= next_waitcnt;
      q         <= next_q;
      step      <= next_step;
      bitcnt    <= next_bitcnt;
      sh        <= next_sh;
      rx        <= next_rx;
      rd        <= next_rd;
      dev       <= next_dev;
      loc       <= next_loc;
      dat       <= next_dat;
      nack      <= next_nack;
      rsp_valid <= next_rsp_valid;
      rsp_data  <= next_rsp_data;
      rsp_nack  <= next_rsp_nack;
      sy1       <= {bus.sda, bus.scl};
      sy2       <= sy1;
      sy3       <= sy2;
      filt      <= next_filt;
    end
  end

  assign cmd_ready        = (st == H_IDLE);
  assign bus.host_scl_o   = 1'b0;
  assign bus.host_scl_oe  = scl_low;
  assign bus.host_sda_o   = 1'b0;
  assign bus.host_sda_oe  = sda_low;
endmodule

// [tb/smb_link_assertions.sv]
module smb_link_assertions #(
  parameter int TMO_LIMIT = 2000
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic host_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  int   hi_cnt;
  int   lo_cnt;
  int   per_cnt;
  logic scl_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // scl high time, low time and rise-to-rise spacing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt  <= 0;
      lo_cnt  <= 0;
      per_cnt <= 1000;
      scl_q   <= 1'b1;
    end else begin
      scl_q  <= scl;
      hi_cnt <= scl ? hi_cnt + 1 : 0;
      lo_cnt <= scl ? 0 : lo_cnt + 1;
      if (scl && !scl_q) begin
        per_cnt <= 1;
      end else if (per_cnt < 1000) begin
        per_cnt <= per_cnt + 1;
      end
    end
  end

  sequence start_seen;
    scl && $past(scl) && $fell(sda);
  endsequence

  AST_NO_SCL_DRIVE: assert property (!dev_scl_oe)
    else $error("device pulls scl");
  AST_OPEN_DRAIN: assert property (!dev_sda_o && !dev_scl_o)
    else $error("device drives a line high");
  AST_NO_DEV_START: assert property (start_seen |-> host_sda_oe)
    else $error("start made without the host");
  AST_START_RELEASE: assert property (
    start_seen |-> ##[1:8] !dev_sda_oe [*8])
    else $error("sda not released after start");
  AST_SDA_EDGE_SCL_LOW: assert property (
    $changed(dev_sda_oe) |-> !scl)
    else $error("device sda changes while scl high");
  AST_SCL_TMO: assert property (
    lo_cnt > TMO_LIMIT + 8 |-> !dev_sda_oe)
    else $error("sda held after scl low timeout");
  AST_HIGH_TIME: assert property ($fell(scl) |-> $past(hi_cnt) >= 159)
    else $error("scl high time too short");
  AST_PERIOD: assert property (scl && !scl_q |-> per_cnt >= 400)
    else $error("scl faster than bus rate");
endmodule

// [tb/smbus_slave_with_eeprom_port_tb_top.sv]
module smbus_slave_with_eeprom_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TMO = 2000;
  localparam int PW  = 100;

  logic       ref_clk            = 1'b0;
  logic       rst_n              = 1'b0;
  logic       address_select_pin = 1'b1;
  logic       cmd_valid          = 1'b0;
  logic       cmd_read           = 1'b0;
  logic [7:0] cmd_dev            = 8'h00;
  logic [7:0] cmd_loc            = 8'h00;
  logic [7:0] cmd_data           = 8'h00;
  logic [7:0] ctl_rd_data        = 8'h3c;
  logic       cmd_ready;
  logic       rsp_valid;
  logic       rsp_nack;
  logic [7:0] rsp_data;
  logic       ctl_wr_valid;
  logic       ctl_wr_first;
  logic       ctl_rd_req;
  logic [7:0] ctl_wr_data;
  logic [8:0] ctl_q[$];
  logic       sda_pulled         = 1'b0;
  int         errors             = 0;
  int         tests_run          = 0;
  int         cycles             = 0;
  int         rd_reqs            = 0;

  smb_link_if link();

  smb_dev #(.TMO_LIMIT(TMO)) u_smb_dev (
    .ref_clk            (ref_clk),
    .rst_n              (rst_n),
    .address_select_pin (address_select_pin),
    .bus                (link),
    .ctl_wr_valid       (ctl_wr_valid),
    .ctl_wr_data        (ctl_wr_data),
    .ctl_wr_first       (ctl_wr_first),
    .ctl_rd_req         (ctl_rd_req),
    .ctl_rd_data        (ctl_rd_data)
  );

  smb_host #(.PROG_WAIT(PW)) u_smb_host (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .bus       (link),
    .cmd_valid (cmd_valid),
    .cmd_ready (cmd_ready),
    .cmd_read  (cmd_read),
    .cmd_dev   (cmd_dev),
    .cmd_loc   (cmd_loc),
    .cmd_data  (cmd_data),
    .rsp_valid (rsp_valid),
    .rsp_data  (rsp_data),
    .rsp_nack  (rsp_nack)
  );

  smb_link_assertions #(.TMO_LIMIT(TMO)) u_smb_link_assertions (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .dev_scl_o   (link.dev_scl_o),
    .dev_scl_oe  (link.dev_scl_oe),
    .dev_sda_o   (link.dev_sda_o),
    .dev_sda_oe  (link.dev_sda_oe),
    .host_sda_oe (link.host_sda_oe),
    .scl         (link.scl),
    .sda         (link.sda)
  );

  always #12.5 ref_clk = ~ref_clk;

  task automatic finish_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one host command; returns read byte and nack flag
  task automatic xfer(input logic rd_op, input logic [7:0] dev,
                      input logic [7:0] loc, input logic [7:0] dat,
                      output logic [7:0] rdat, output logic nack);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    cmd_valid  <= 1'b1;
    cmd_read   <= rd_op;
    cmd_dev    <= dev;
    cmd_loc    <= loc;
    cmd_data   <= dat;
    sda_pulled <= 1'b0;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 40000) begin
      @(negedge ref_clk);
      n++;
    end
    if (rsp_valid !== 1'b1) begin
      errors++;
    end
    rdat = rsp_data;
    nack = rsp_nack;
  endtask

  // controller bytes, device sda activity and the hang limit
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (ctl_wr_valid === 1'b1) begin
      ctl_q.push_back({ctl_wr_first, ctl_wr_data});
    end
    if (link.dev_sda_oe === 1'b1) begin
      sda_pulled <= 1'b1;
    end
    if (ctl_rd_req === 1'b1) begin
      rd_reqs <= rd_reqs + 1;
    end
    if (cycles == 100000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    logic [7:0] rd;
    logic       nk;
    int         n;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (500) @(posedge ref_clk);
    // eeprom byte at the top location, written then read back
    xfer(1'b0, 8'ha2, 8'hff, 8'h5a, rd, nk);
    check({8'h00, nk}, 9'h000);
    check({8'h00, sda_pulled}, 9'h001);
    // host stays off the bus for the programming wait
    n = 0;
    while (cmd_ready !== 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    check(9'(n), 9'(PW));
    xfer(1'b1, 8'ha2, 8'hff, 8'h00, rd, nk);
    check({nk, rd}, 9'h05a);
    check(9'(ctl_q.size()), 9'h000);
    // controller write with the select pin grounded
    @(posedge ref_clk);
    address_select_pin <= 1'b0;
    xfer(1'b0, 8'hb0, 8'h11, 8'h22, rd, nk);
    check({8'h00, nk}, 9'h000);
    check(9'(ctl_q.size()), 9'h002);
    check(ctl_q[0], 9'h111);
    check(ctl_q[1], 9'h022);
    // controller read: command byte, restart, byte from the user port
    xfer(1'b1, 8'hb0, 8'h44, 8'h00, rd, nk);
    check({nk, rd}, 9'h03c);
    check(ctl_q[2], 9'h144);
    check(9'(rd_reqs), 9'h001);
    // eeprom address of the other select value gets no answer
    xfer(1'b0, 8'ha2, 8'h00, 8'h33, rd, nk);
    check({8'h00, nk}, 9'h001);
    check({8'h00, sda_pulled}, 9'h000);
    finish_test();
  end
endmodule
